// ==== rtl/read_pacing.sv ====
// Behaviour
// R1 - software must not enable source queuing and read pacing together
// R2 - pacing acts on every port; its registers sit in upstream space
// R3 - spreading spaces a port's reads by request size and link bandwidth
// R4 - forward at twice link rate first, then once after outstanding threshold
// R5 - spreading acts only when pacing and spreading disable bits are clear
// R6 - keep forwarding until awaited completion data reaches the width's limit
// R7 - limit counts requested but not yet returned DWords of four bytes
// R8 - at the limit hold further reads until completions bring count below
// R9 - too many held reads withdraw non-posted read credit from the port
// R10 - pacing disable bits 5,4,1,0 per port, one disables, reset set
// R11 - spreading disable bits 5,4,1,0 per port, one disables, reset clear
// R12 - limit chosen by link width: first register two lanes, second one lane
// R13 - registers also reachable through the legacy non-transparent window
// R14 - outstanding count rises by forwarded length, falls by completion length
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "pacing_params.svh"
module read_pacing
  import pacing_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nt_legacy_mode,
  input wire logic [3:0] link_two_lane,
  input wire logic [3:0] rd_req_valid,
  input wire logic [39:0] rd_req_len,
  output logic [3:0] np_credit_ok,
  output logic fwd_valid,
  output logic [1:0] fwd_src,
  output logic [9:0] fwd_len,
  input wire logic fwd_ready,
  input wire logic cpl_valid,
  input wire logic [1:0] cpl_dst,
  input wire logic [9:0] cpl_len
);
  top_s st_ff;
  top_s nxt_st;
  logic nt_mode;
  logic [3:0] lane2;
  logic [3:0] elig;
  logic [3:0] take;
  logic [9:0] head_len [NPORT];
  logic [15:0] outst [NPORT];
  logic [2:0] held [NPORT];
  logic [3:0] credit;
  logic setup;
  logic commit;
  logic hit;
  logic [11:0] ofs;
  logic [31:0] rd_val;
  logic [31:0] wmask;
  logic found;
  logic [1:0] idx;
  logic [1:0] pick;

  sync_bits #(.W(1)) u_sync_nt (
    .pclk(pclk),
    .presetn(presetn),
    .d(nt_legacy_mode),
    .q(nt_mode)
  );

  sync_bits #(.W(4)) u_sync_lane (
    .pclk(pclk),
    .presetn(presetn),
    .d(link_two_lane),
    .q(lane2)
  );

  // packs the per-port disable bits into positions 5,4,1,0
  function automatic logic [31:0] port_bits(input logic [3:0] b);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[`BIT_P0] = b[0];
    r[`BIT_P1] = b[1];
    r[`BIT_P4] = b[2];
    r[`BIT_P5] = b[3];
    return r;
  endfunction : port_bits

  function automatic logic [3:0] bits_port(input logic [31:0] w);
    return {w[`BIT_P5], w[`BIT_P4], w[`BIT_P1], w[`BIT_P0]};
  endfunction : bits_port

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic [15:0] limit;
    // x2 links use the first limit, x1 links the second
    assign limit = lane2[p] ? st_ff.lim2[15:0] : st_ff.lim1[15:0]; // [R12]
    port_pacer u_pacer (
      .pclk(pclk),
      .presetn(presetn),
      .req_valid(rd_req_valid[p]),
      .req_len(rd_req_len[p*10 +: 10]),
      .pace_en(!st_ff.pace_dis[p]), // [R2]
      .spread_en(!st_ff.spread_dis[p]), // [R5]
      .lane2(lane2[p]),
      .limit(limit),
      .take(take[p]),
      .cpl_valid(cpl_valid && (cpl_dst == 2'(p))),
      .cpl_len(cpl_len),
      .eligible(elig[p]),
      .head_len(head_len[p]),
      .outstanding(outst[p]),
      .held(held[p]),
      .credit_ok(credit[p])
    );
  end

  assign np_credit_ok = credit; // [R9]

  // decode: upstream window always, virtual window only in legacy nt mode
  always_comb begin
    ofs = paddr[11:0];
    hit = (paddr[15:12] == `UP_WIN_BASE) ||
      ((paddr[15:12] == `NT_WIN_BASE) && nt_mode); // [R13]
    rd_val = 32'h0000_0000;
    if (hit) begin
      unique case (ofs)
        `OFS_PACE_DIS: rd_val = port_bits(st_ff.pace_dis);
        `OFS_SPREAD_DIS: rd_val = port_bits(st_ff.spread_dis);
        `OFS_LIMIT_X2: rd_val = st_ff.lim2;
        `OFS_LIMIT_X1: rd_val = st_ff.lim1;
        `OFS_STAT_OUT01: rd_val = {outst[1], outst[0]};
        `OFS_STAT_OUT45: rd_val = {outst[3], outst[2]};
        `OFS_STAT_QUEUE: rd_val = {12'h000, credit, 1'b0, held[3], 1'b0, held[2],
          1'b0, held[1], 1'b0, held[0]};
        default: hit = 1'b0;
      endcase
    end
  end

  always_comb begin
    wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    setup = psel && !penable;
    commit = psel && penable && st_ff.pready && !st_ff.pslverr;
  end

  // round robin over eligible ports, starting after the last winner
  always_comb begin
    found = 1'b0;
    pick = st_ff.rr;
    idx = 2'h0;
    for (int i = 1; i <= NPORT; i++) begin
      idx = 2'(st_ff.rr + 2'(i));
      if (!found && elig[idx]) begin
        found = 1'b1;
        pick = idx;
      end
    end
    take = 4'h0;
    if ((!st_ff.fwd_valid || fwd_ready) && found) begin
      take[pick] = 1'b1; // [R6]
    end
  end

  always_comb begin
    nxt_st = st_ff;
    // apb: answer registered in the setup cycle, zero wait states
    nxt_st.pready = setup;
    nxt_st.pslverr = setup && !hit;
    nxt_st.prdata = (setup && !pwrite && hit) ? rd_val : 32'h0000_0000;
    if (commit && pwrite) begin
      unique case (ofs)
        `OFS_PACE_DIS: begin
          nxt_st.pace_dis = bits_port((port_bits(st_ff.pace_dis) & ~wmask) |
            (pwdata & wmask)); // [R10]
        end
        `OFS_SPREAD_DIS: begin
          nxt_st.spread_dis = bits_port((port_bits(st_ff.spread_dis) & ~wmask) |
            (pwdata & wmask)); // [R11]
        end
        `OFS_LIMIT_X2: nxt_st.lim2 = (st_ff.lim2 & ~wmask) | (pwdata & wmask);
        `OFS_LIMIT_X1: nxt_st.lim1 = (st_ff.lim1 & ~wmask) | (pwdata & wmask);
        default: nxt_st.lim1 = st_ff.lim1;
      endcase
    end
    // forwarding stage toward the upstream link
    if (st_ff.fwd_valid && fwd_ready) begin
      nxt_st.fwd_valid = 1'b0;
    end
    if (take != 4'h0) begin
      nxt_st.fwd_valid = 1'b1;
      nxt_st.fwd_src = pick;
      nxt_st.fwd_len = head_len[pick];
      nxt_st.rr = pick;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.pace_dis <= `PACE_DIS_RST; // [R10]
      st_ff.spread_dis <= `SPREAD_DIS_RST; // [R11]
      st_ff.lim2 <= `LIMIT_X2_RST;
      st_ff.lim1 <= `LIMIT_X1_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign fwd_valid = st_ff.fwd_valid;
  assign fwd_src = st_ff.fwd_src;
  assign fwd_len = st_ff.fwd_len;
endmodule : read_pacing

// ==== inc/pacing_params.svh ====
`ifndef PACING_PARAMS_SVH
`define PACING_PARAMS_SVH
// register byte offsets inside one window
`define OFS_PACE_DIS 12'h544
`define OFS_SPREAD_DIS 12'h548
`define OFS_LIMIT_X2 12'h54C
`define OFS_LIMIT_X1 12'h550
`define OFS_STAT_OUT01 12'h560
`define OFS_STAT_OUT45 12'h564
`define OFS_STAT_QUEUE 12'h568
// window bases: upstream space and non-transparent virtual interface
`define UP_WIN_BASE 4'h0
`define NT_WIN_BASE 4'h1
// port disable bit positions inside the control registers
`define BIT_P0 0
`define BIT_P1 1
`define BIT_P4 4
`define BIT_P5 5
`define PACE_DIS_RST 4'hF
`define SPREAD_DIS_RST 4'h0
`define LIMIT_X2_RST 32'h0000_0200
`define LIMIT_X1_RST 32'h0000_0100
`define BYTES_PER_DW 16'h0004
// per-lane link rate against the core clock
`define CLK_MHZ 50
`define LANE_MBYTE_S 500
`define LANE_BYTES_PER_CYC (`LANE_MBYTE_S / `CLK_MHZ)
`define HOLD_DEPTH 4
`endif

// ==== inc/pacing_pkg.sv ====
package pacing_pkg;
  localparam int NPORT = 4;
  typedef logic [9:0] dw_len_t;
  typedef logic [15:0] dw_cnt_t;
  typedef struct packed {
    logic [3:0][9:0] q;
    logic [2:0] cnt;
    logic [1:0] rd;
    logic [1:0] wr;
    logic [15:0] outst;
    logic signed [15:0] budget;
    logic ok;
  } pacer_s;
  typedef struct packed {
    logic [3:0] pace_dis;
    logic [3:0] spread_dis;
    logic [31:0] lim2;
    logic [31:0] lim1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fwd_valid;
    logic [1:0] fwd_src;
    logic [9:0] fwd_len;
    logic [1:0] rr;
  } top_s;
endpackage : pacing_pkg

// ==== rtl/sync_bits.sv ====
`timescale 1ns/1ps
module sync_bits #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;
  sync_s st_ff;
  sync_s nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q = st_ff.s2;
endmodule : sync_bits

// ==== rtl/port_pacer.sv ====
`timescale 1ns/1ps
`include "pacing_params.svh"
module port_pacer
  import pacing_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req_valid,
  input wire logic [9:0] req_len,
  input wire logic pace_en,
  input wire logic spread_en,
  input wire logic lane2,
  input wire logic [15:0] limit,
  input wire logic take,
  input wire logic cpl_valid,
  input wire logic [9:0] cpl_len,
  output logic eligible,
  output logic [9:0] head_len,
  output logic [15:0] outstanding,
  output logic [2:0] held,
  output logic credit_ok
);
  pacer_s st_ff;
  pacer_s nxt_st;
  logic push;
  logic spread_on;
  logic signed [15:0] rate;
  logic [16:0] sum;
  always_comb begin
    nxt_st = st_ff;
    push = req_valid && st_ff.ok;
    spread_on = pace_en && spread_en; // [R5]
    // 2x link rate until half the limit is outstanding, then 1x
    rate = lane2 ? 16'(2 * `LANE_BYTES_PER_CYC) : 16'(`LANE_BYTES_PER_CYC);
    if (st_ff.outst < (limit >> 1)) begin
      rate = rate <<< 1; // [R4]
    end
    if (push) begin
      nxt_st.q[st_ff.wr] = req_len;
      nxt_st.wr = st_ff.wr + 2'h1;
    end
    if (take) begin
      nxt_st.rd = st_ff.rd + 2'h1;
    end
    nxt_st.cnt = 3'(st_ff.cnt + {2'h0, push} - {2'h0, take});
    // outstanding DWords: up on forward, down on completion [R14] [R7]
    sum = {1'b0, st_ff.outst} + (take ? {7'h0, st_ff.q[st_ff.rd]} : 17'h0);
    if (cpl_valid) begin
      sum = (sum > {7'h0, cpl_len}) ? sum - {7'h0, cpl_len} : 17'h0;
    end
    nxt_st.outst = (sum > 17'h0FFFF) ? 16'hFFFF : sum[15:0];
    // byte budget refills at link rate; never banks idle time
    if (st_ff.budget < 0) begin
      nxt_st.budget = st_ff.budget + rate;
      if (nxt_st.budget > 0) begin
        nxt_st.budget = 16'sh0;
      end
    end
    if (take && spread_on) begin
      nxt_st.budget = nxt_st.budget - 16'(st_ff.q[st_ff.rd] * `BYTES_PER_DW); // [R3]
    end
    nxt_st.ok = nxt_st.cnt < 3'(`HOLD_DEPTH); // [R9]
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // held requests wait while the limit is reached [R8] [R6]
  assign eligible = (st_ff.cnt != 3'h0) && (!pace_en ||
    ((st_ff.outst < limit) && (!spread_on || st_ff.budget >= 0)));
  assign head_len = st_ff.q[st_ff.rd];
  assign outstanding = st_ff.outst;
  assign held = st_ff.cnt;
  assign credit_ok = st_ff.ok;
endmodule : port_pacer

// ==== verification/read_pacing_assertions.sv ====
`timescale 1ns/1ps
module read_pacing_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] np_credit_ok,
  input wire logic fwd_valid,
  input wire logic [1:0] fwd_src,
  input wire logic [9:0] fwd_len,
  input wire logic fwd_ready
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_has_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  chk_error_with_ready: assert property (pslverr |-> pready)
    else $error("error outside access");
  chk_data_idle_zero: assert property (!pready |-> prdata == '0)
    else $error("read data outside access");
  chk_unmapped_error: assert property (psel && !penable && paddr == 16'h0554 |=> pslverr)
    else $error("unmapped offset accepted");
  chk_pace_bits_only: assert property (pready && !pwrite && paddr == 16'h0544
    |-> prdata[31:6] == '0 && prdata[3:2] == '0)
    else $error("pace register reserved bits set");
  chk_forward_held: assert property (fwd_valid && !fwd_ready
    |=> fwd_valid && $stable(fwd_src) && $stable(fwd_len))
    else $error("forward dropped before ready");
  cover property (fwd_valid && fwd_ready);
  cover property (pslverr);
  cover property (np_credit_ok != 4'hF);
endmodule : read_pacing_assertions

bind read_pacing read_pacing_assertions i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .np_credit_ok(np_credit_ok), .fwd_valid(fwd_valid), .fwd_src(fwd_src),
  .fwd_len(fwd_len), .fwd_ready(fwd_ready)
);

// ==== verification/rc_model.sv ====
`timescale 1ns/1ps
module rc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fwd_valid,
  input wire logic [1:0] fwd_src,
  input wire logic [9:0] fwd_len,
  input wire logic hold_cpl,
  input wire logic stall,
  output logic fwd_ready,
  output logic cpl_valid,
  output logic [1:0] cpl_dst,
  output logic [9:0] cpl_len
);
  logic [11:0] q[$];
  logic [3:0] tick;
  // reads only, no source queuing on this side
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.delete();
      {fwd_ready, cpl_valid, cpl_dst, cpl_len, tick} <= '0;
    end else begin
      fwd_ready <= !stall;
      tick <= tick + 4'h1;
      if (fwd_valid && fwd_ready) q.push_back({fwd_src, fwd_len});
      if (!hold_cpl && tick == 4'h0 && q.size() > 0) begin
        cpl_valid <= 1'b1;
        {cpl_dst, cpl_len} <= q.pop_front();
      end else begin
        cpl_valid <= 1'b0;
        // idle lines flip so a stale value never passes for data
        {cpl_dst, cpl_len} <= ~{cpl_dst, cpl_len};
      end
    end
  end
endmodule : rc_model

// ==== verification/read_pacing_tb.sv ====
`timescale 1ns/1ps
module read_pacing_tb;
  logic pclk, presetn, psel, penable, pwrite, nt_legacy_mode, pready, pslverr, e;
  logic fwd_valid, fwd_ready, cpl_valid, hold_cpl, stall;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb, link_two_lane, rd_req_valid, np_credit_ok;
  logic [39:0] rd_req_len;
  logic [1:0] fwd_src, cpl_dst;
  logic [9:0] fwd_len, cpl_len;
  int errors, num_checks, nfwd, t_now, t_a, t_b, base;
  logic [15:0] ofs[4] = '{16'h0544, 16'h0548, 16'h054C, 16'h0550};
  logic [31:0] rstv[4] = '{32'h33, 32'h0, 32'h200, 32'h100};
  logic [31:0] lim[4] = '{32'h1000, 32'h50, 32'h1000, 32'h50};
  logic [31:0] pace[4] = '{32'h0, 32'h0, 32'h33, 32'h0};
  // last pass puts port 1 on a two-lane link with a small one-lane limit
  logic [3:0] lanes[4] = '{4'h0, 4'h0, 4'h0, 4'h2};
  int lo[4] = '{7, 15, 1, 4};
  int hi[4] = '{10, 18, 3, 6};
  logic [11:0] last_fwd;

  read_pacing i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nt_legacy_mode(nt_legacy_mode), .link_two_lane(link_two_lane),
    .rd_req_valid(rd_req_valid), .rd_req_len(rd_req_len), .np_credit_ok(np_credit_ok),
    .fwd_valid(fwd_valid), .fwd_src(fwd_src), .fwd_len(fwd_len), .fwd_ready(fwd_ready),
    .cpl_valid(cpl_valid), .cpl_dst(cpl_dst), .cpl_len(cpl_len));
  rc_model i_rc (
    .pclk(pclk), .presetn(presetn), .fwd_valid(fwd_valid), .fwd_src(fwd_src),
    .fwd_len(fwd_len), .hold_cpl(hold_cpl), .stall(stall), .fwd_ready(fwd_ready),
    .cpl_valid(cpl_valid), .cpl_dst(cpl_dst), .cpl_len(cpl_len));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    t_now <= t_now + 1;
    if (fwd_valid && fwd_ready) begin
      nfwd <= nfwd + 1;
      last_fwd <= {fwd_src, fwd_len};
      t_a <= t_b;
      t_b <= t_now;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string n);
    num_checks++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic final_report;
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    // one idle edge so the next call never re-drives psel in this step
    @(posedge pclk);
  endtask : apb

  // waits for credit, since a push without it is silently dropped
  task automatic push(input int p, input logic [9:0] l);
    while (np_credit_ok[p] !== 1'b1) begin
      @(posedge pclk);
    end
    rd_req_valid[p] <= 1'b1;
    rd_req_len[p*10+:10] <= l;
    @(posedge pclk);
    rd_req_valid[p] <= 1'b0;
    rd_req_len <= ~rd_req_len;
    @(posedge pclk);
  endtask : push

  initial begin
    {psel, penable, pwrite, nt_legacy_mode, hold_cpl, stall} = 6'b000010;
    {paddr, pwdata, link_two_lane, rd_req_valid, rd_req_len} = '0;
    pstrb = 4'hF;
    presetn = 1'b0;
    do_reset();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ofs[i], '0, r, e);
      chk(r, rstv[i], "reset value");
    end
    apb(1'b0, 16'h0554, '0, r, e);
    chk({31'b0, e}, 32'h1, "unmapped error");
    apb(1'b0, 16'h1544, '0, r, e);
    chk({31'b0, e}, 32'h1, "closed window error");
    nt_legacy_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b1, 16'h1548, 32'hFFFF_FFFF, r, e);
    apb(1'b0, 16'h0548, '0, r, e);
    chk(r, 32'h33, "spread bits via window");
    apb(1'b1, 16'h0544, '0, r, e);
    apb(1'b1, 16'h0550, 32'h8, r, e);
    base = nfwd;
    stall <= 1'b1;
    repeat (2) push(0, 10'd4);
    stall <= 1'b0;
    repeat (4) push(0, 10'd4);
    repeat (20) @(posedge pclk);
    chk(nfwd - base, 2, "forwards at limit");
    apb(1'b0, 16'h0560, '0, r, e);
    chk(r[15:0], 16'd8, "outstanding dwords");
    apb(1'b0, 16'h0568, '0, r, e);
    chk({r[16], r[2:0]}, 4'b0100, "held and credit");
    hold_cpl <= 1'b0;
    repeat (300) @(posedge pclk);
    chk(nfwd - base, 6, "forwards after completions");
    chk({20'h0, last_fwd}, {20'h0, 2'd0, 10'd4}, "forward source and length");
    apb(1'b0, 16'h0560, '0, r, e);
    chk(r[15:0], 16'd0, "outstanding drained");
    chk({31'b0, np_credit_ok[0]}, 32'h1, "credit back");
    hold_cpl <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      link_two_lane <= lanes[k];
      do_reset();
      apb(1'b1, 16'h0544, pace[k], r, e);
      apb(1'b1, 16'h0550, lim[k], r, e);
      repeat (2) push(1, 10'd40);
      repeat (40) @(posedge pclk);
      chk({31'b0, t_b - t_a >= lo[k] && t_b - t_a <= hi[k]}, 1, "spacing");
      chk({20'h0, last_fwd}, {20'h0, 2'd1, 10'd40}, "spaced forward source and length");
    end
    final_report();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    final_report();
  end
endmodule : read_pacing_tb
